// ### aosw_consts.svh
`ifndef AOSW_CONSTS_SVH
`define AOSW_CONSTS_SVH

// ==========================================================
// status word layout
`define AOSW_WORD_W        16
`define AOSW_BIT_BUSY      0
`define AOSW_BIT_RD_DONE   1
`define AOSW_BIT_WR_DONE   2
`define AOSW_BIT_INVALID   3
`define AOSW_BIT_CONV_ERR  4
`define AOSW_BIT_SPEED     5
`define AOSW_BIT_LIMIT     8
`define AOSW_BIT_SUPPLY    9
`define AOSW_BIT_PULSE     11
`define AOSW_BIT_UNIT_OK   12
`define AOSW_RSVD_MASK     16'he4c0
`define AOSW_WORD_RST      16'h0000
`define AOSW_CFG_RST       16'h0000

// ==========================================================
// heartbeat timing
`define AOSW_CLK_KHZ       50000
`define AOSW_HB_HALF_MS    500
`define AOSW_HB_CNT_W      25

`endif

// ### aosw_pkg.sv
package aosw_pkg;

	// ==========================================================
	// transfer state of the block read / write handshake
	typedef enum logic [1:0] {
		AOSW_IDLE,
		AOSW_READ,
		AOSW_WRITE
	} aosw_xfer_e;

	// one data word delivered by a block write instruction
	typedef struct packed {
		logic [15:0] data;
		logic        invalid;
	} aosw_wr_s;

	// configured conversion limits
	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
	} aosw_limits_s;

endpackage

// ### aosw_heartbeat.sv
`timescale 1ns/1ps
`include "aosw_consts.svh"

module aosw_heartbeat #(
	parameter int unsigned HALF_CYCLES = `AOSW_HB_HALF_MS * `AOSW_CLK_KHZ
) (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic pause_i,
	output logic      pulse_o
);

	logic [`AOSW_HB_CNT_W-1:0] cnt_reg;
	logic                      last_cnt;

	localparam logic [`AOSW_HB_CNT_W-1:0] LAST =
		`AOSW_HB_CNT_W'(HALF_CYCLES - 1);

	assign last_cnt = (cnt_reg == LAST);

	// ==========================================================
	// half period counter; frozen during a pause so the phase
	// carries on where it stopped instead of restarting
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= '0;
		end else if (!pause_i) begin
			cnt_reg <= last_cnt ? '0 : cnt_reg + 1'b1;
		end
	end

	// level flips at the end of every half period
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pulse_o <= 1'b0;
		end else if (!pause_i && last_cnt) begin
			pulse_o <= ~pulse_o;
		end
	end

	// ==========================================================
	// checks
	a_hb_toggle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(last_cnt && !pause_i) |=> (pulse_o != $past(pulse_o)))
		else $error("heartbeat missed its toggle");
	a_hb_steady: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!(last_cnt && !pause_i) |=> $stable(pulse_o))
		else $error("heartbeat changed outside a half period end");

endmodule // aosw_heartbeat

// ### aosw_status_word.sv
// Notes on behaviour
// - busy, read-complete, write-complete bits 0-2 follow block transfers.
// - invalid write sets bit 3; next valid write clears it.
// - invalid or erroneous data is dropped; previous configuration stays.
// - conversion error sets bit 4; next valid write clears it.
// - bit 5 shows speed mode: 0 normal, 1 high speed.
// - bit 8 set when written data is above upper or below lower limit.
// - bit 8 cleared when written data lies within the limits.
// - bit 9 high while the external supply is present.
// - bit 11 toggles at 1 Hz, 0.5 s high, 0.5 s low.
// - heartbeat pauses during a nonvolatile write, resumes after.
// - bit 12 set on diagnostic pass, cleared on internal fault.
`timescale 1ns/1ps
`include "aosw_consts.svh"

module aosw_status_word #(
	parameter int unsigned HB_HALF_CYCLES =
		`AOSW_HB_HALF_MS * `AOSW_CLK_KHZ
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   nrst_i,
	input  wire logic                   xfer_start_i,
	input  wire logic                   xfer_is_write_i,
	input  wire logic                   xfer_end_i,
	input  wire logic                   block_write_instruction_i,
	input  wire aosw_pkg::aosw_wr_s     wr_i,
	input  wire logic                   conv_err_i,
	input  wire aosw_pkg::aosw_limits_s limits_i,
	input  wire logic                   speed_high_i,
	input  wire logic                   ext_supply_i,
	input  wire logic                   nvm_write_busy_i,
	input  wire logic                   diag_pass_i,
	input  wire logic                   diag_fault_i,
	output logic [`AOSW_WORD_W-1:0]     unit_status_word_o,
	output logic [`AOSW_WORD_W-1:0]     applied_cfg_o,
	output logic                        apply_o
);

	aosw_pkg::aosw_xfer_e xfer_reg;
	logic                 rd_done_reg;
	logic                 wr_done_reg;
	logic                 invalid_reg;
	logic                 conv_err_reg;
	logic                 limit_reg;
	logic                 unit_ok_reg;
	logic                 pulse_lvl;
	logic                 busy;
	logic                 good_wr;
	logic                 bad_wr;
	logic                 in_range;
	logic [`AOSW_WORD_W-1:0] word_next;

	// window test, shared by the flag logic and its checks
	function automatic logic within_limits(
		input logic [15:0]          d,
		input aosw_pkg::aosw_limits_s l
	);
		within_limits = (d <= l.upper) && (d >= l.lower);
	endfunction

	// ==========================================================
	// write classification
	// a conversion error in the same cycle spoils the word too
	assign bad_wr   = block_write_instruction_i &&
		(wr_i.invalid || conv_err_i);
	assign good_wr  = block_write_instruction_i && !bad_wr;
	assign in_range = within_limits(wr_i.data, limits_i);
	assign busy     = (xfer_reg != aosw_pkg::AOSW_IDLE);

	// ==========================================================
	// handshake state of the block transfer instructions
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			xfer_reg <= aosw_pkg::AOSW_IDLE;
		end else begin
			case (xfer_reg)
				aosw_pkg::AOSW_IDLE: begin
					if (xfer_start_i) begin
						xfer_reg <= xfer_is_write_i ?
							aosw_pkg::AOSW_WRITE : aosw_pkg::AOSW_READ;
					end
				end
				aosw_pkg::AOSW_READ,
				aosw_pkg::AOSW_WRITE: begin
					if (xfer_end_i) begin
						xfer_reg <= aosw_pkg::AOSW_IDLE;
					end
				end
				default: begin
					xfer_reg <= aosw_pkg::AOSW_IDLE;
				end
			endcase
		end
	end

	// completion flags stand until the next transfer begins
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_done_reg <= 1'b0;
			wr_done_reg <= 1'b0;
		end else if (busy && xfer_end_i) begin
			rd_done_reg <= (xfer_reg == aosw_pkg::AOSW_READ);
			wr_done_reg <= (xfer_reg == aosw_pkg::AOSW_WRITE);
		end else if (!busy && xfer_start_i) begin
			rd_done_reg <= 1'b0;
			wr_done_reg <= 1'b0;
		end
	end

	// ==========================================================
	// data error flags; a set always beats a clear
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			invalid_reg <= 1'b0;
		end else if (block_write_instruction_i && wr_i.invalid) begin
			invalid_reg <= 1'b1;
		end else if (good_wr) begin
			invalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			conv_err_reg <= 1'b0;
		end else if (conv_err_i) begin
			conv_err_reg <= 1'b1;
		end else if (good_wr) begin
			conv_err_reg <= 1'b0;
		end
	end

	// limit flag judged only on data actually taken
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			limit_reg <= 1'b0;
		end else if (good_wr) begin
			limit_reg <= !in_range;
		end
	end

	// ==========================================================
	// configuration: bad words never reach it, so the last good
	// setting keeps driving the output stage
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			applied_cfg_o <= `AOSW_CFG_RST;
			apply_o       <= 1'b0;
		end else begin
			apply_o <= good_wr;
			if (good_wr) begin
				applied_cfg_o <= wr_i.data;
			end
		end
	end

	// ==========================================================
	// self diagnostic; a fault outranks a pass in the same cycle
	// so a broken unit can never look healthy
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			unit_ok_reg <= 1'b0;
		end else if (diag_fault_i) begin
			unit_ok_reg <= 1'b0;
		end else if (diag_pass_i) begin
			unit_ok_reg <= 1'b1;
		end
	end

	// ==========================================================
	// heartbeat
	aosw_heartbeat #(
		.HALF_CYCLES (HB_HALF_CYCLES)
	) u_heartbeat (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.pause_i   (nvm_write_busy_i),
		.pulse_o   (pulse_lvl)
	);

	// ==========================================================
	// word assembly; reserved positions stay zero
	always_comb begin
		word_next                     = `AOSW_WORD_RST;
		word_next[`AOSW_BIT_BUSY]     = busy;
		word_next[`AOSW_BIT_RD_DONE]  = rd_done_reg;
		word_next[`AOSW_BIT_WR_DONE]  = wr_done_reg;
		word_next[`AOSW_BIT_INVALID]  = invalid_reg;
		word_next[`AOSW_BIT_CONV_ERR] = conv_err_reg;
		word_next[`AOSW_BIT_SPEED]    = speed_high_i;
		word_next[`AOSW_BIT_LIMIT]    = limit_reg;
		word_next[`AOSW_BIT_SUPPLY]   = ext_supply_i;
		word_next[`AOSW_BIT_PULSE]    = pulse_lvl;
		word_next[`AOSW_BIT_UNIT_OK]  = unit_ok_reg;
	end

	// registered so the host never samples a mid-update word
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			unit_status_word_o <= `AOSW_WORD_RST;
		end else begin
			unit_status_word_o <= word_next;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	a_busy_shown: assert property (
		(!busy && xfer_start_i) |=> ##1 unit_status_word_o[0])
		else $error("busy bit not shown after transfer start");
	a_done_kind: assert property (
		(xfer_reg == aosw_pkg::AOSW_READ && xfer_end_i)
		|=> ##1 (unit_status_word_o[2:0] == 3'h2))
		else $error("read completion not shown");
	a_invalid_set: assert property (
		(block_write_instruction_i && wr_i.invalid)
		|=> invalid_reg ##1 unit_status_word_o[3])
		else $error("invalid flag not raised");
	a_bad_dropped: assert property (
		bad_wr |=> ($stable(applied_cfg_o) && !apply_o))
		else $error("erroneous data applied");
	a_conv_err_set: assert property (
		conv_err_i |=> conv_err_reg ##1 unit_status_word_o[4])
		else $error("conversion error flag not raised");
	// level inputs feed word_next directly, so the word lags them by
	// exactly one edge
	a_speed_bit: assert property (
		##1 (unit_status_word_o[`AOSW_BIT_SPEED] ==
		$past(speed_high_i)))
		else $error("speed bit mismatch");
	a_limit_over: assert property (
		(good_wr && !within_limits(wr_i.data, limits_i))
		|=> ##1 unit_status_word_o[8])
		else $error("limit flag not raised");
	a_limit_clear: assert property (
		(good_wr && within_limits(wr_i.data, limits_i))
		|=> ##1 !unit_status_word_o[8])
		else $error("limit flag not cleared");
	a_supply_bit: assert property (
		##1 (unit_status_word_o[`AOSW_BIT_SUPPLY] ==
		$past(ext_supply_i)))
		else $error("supply bit mismatch");
	a_pulse_frozen: assert property (
		nvm_write_busy_i |=> $stable(pulse_lvl))
		else $error("heartbeat moved during nonvolatile write");
	a_fault_clears: assert property (
		diag_fault_i |=> ##1 !unit_status_word_o[12])
		else $error("unit ok flag survived a fault");
	a_rsvd_zero: assert property (
		(unit_status_word_o & `AOSW_RSVD_MASK) == `AOSW_WORD_RST)
		else $error("reserved bit set");

	c_read_done: cover property (
		(xfer_reg == aosw_pkg::AOSW_READ) ##1 rd_done_reg);
	c_bad_write: cover property (bad_wr ##1 invalid_reg);
	c_recover: cover property (invalid_reg && good_wr);
	c_pulse_flip: cover property ($changed(pulse_lvl));

endmodule // aosw_status_word

// ### aosw_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// host processor: block instructions and data words, driven at negedge
module aosw_host_model (
	input  wire logic          ref_clk_i,
	output logic               xfer_start_o,
	output logic               xfer_is_write_o,
	output logic               xfer_end_o,
	output logic               wr_stb_o,
	output aosw_pkg::aosw_wr_s wr_o
);
	// idle at time zero; data lines never rest on a value a check expects
	initial begin
		xfer_start_o    = 1'b0;
		xfer_is_write_o = 1'b0;
		xfer_end_o      = 1'b0;
		wr_stb_o        = 1'b0;
		wr_o            = '{data: 16'hc3a5, invalid: 1'b1};
	end

	// start pulse; the kind qualifier flips afterwards so it is not reused
	task automatic start_xfer(input logic is_wr);
		xfer_start_o    = 1'b1;
		xfer_is_write_o = is_wr;
		@(negedge ref_clk_i);
		xfer_start_o    = 1'b0;
		xfer_is_write_o = ~is_wr;
	endtask

	// end pulse of the running instruction
	task automatic end_xfer();
		xfer_end_o = 1'b1;
		@(negedge ref_clk_i);
		xfer_end_o = 1'b0;
	endtask

	// one data word; released lines show the inverse of the last value
	task automatic write_word(input logic [15:0] d, input logic inv);
		wr_o     = '{data: d, invalid: inv};
		wr_stb_o = 1'b1;
		@(negedge ref_clk_i);
		wr_stb_o = 1'b0;
		wr_o     = '{data: ~d, invalid: ~inv};
	endtask
endmodule // aosw_host_model

// ### tb.sv
`timescale 1ns/1ps
`include "aosw_consts.svh"

// ==========================================================
// status word bench: host model drives transfers, bench the unit side
module tb;
	localparam int unsigned HB = 8;
	logic                   ref_clk_i, nrst_i, conv_err_i, speed_high_i;
	logic                   ext_supply_i, nvm_write_busy_i, hb;
	logic                   diag_pass_i, diag_fault_i;
	logic                   start, is_wr, xend, stb, apply;
	aosw_pkg::aosw_wr_s     wr;
	aosw_pkg::aosw_limits_s limits;
	logic [15:0]            word, cfg;
	int                     errors = 0, n_compared = 0, n_apply = 0, n;
	logic [15:0]            wd [6] = '{16'h0100, 16'h0801, 16'h0800,
		16'h00ff, 16'h0555, 16'h0400};
	logic [15:0]            ec [6] = '{16'h0100, 16'h0801, 16'h0800,
		16'h00ff, 16'h00ff, 16'h0400};
	logic [5:0]             wi = 6'h10, el = 6'h1a;

	// free running clock, 50 MHz
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	aosw_host_model host (.ref_clk_i(ref_clk_i), .xfer_start_o(start),
		.xfer_is_write_o(is_wr), .xfer_end_o(xend), .wr_stb_o(stb),
		.wr_o(wr));

	aosw_status_word #(.HB_HALF_CYCLES(HB)) DUT (.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i), .xfer_start_i(start), .xfer_is_write_i(is_wr),
		.xfer_end_i(xend), .block_write_instruction_i(stb), .wr_i(wr),
		.conv_err_i(conv_err_i), .limits_i(limits),
		.speed_high_i(speed_high_i), .ext_supply_i(ext_supply_i),
		.nvm_write_busy_i(nvm_write_busy_i), .diag_pass_i(diag_pass_i),
		.diag_fault_i(diag_fault_i), .unit_status_word_o(word),
		.applied_cfg_o(cfg), .apply_o(apply));

	// accepted words, counted to catch a spoiled word that slipped through
	always @(posedge ref_clk_i) if (apply === 1'b1) n_apply++;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic settle(input int c);
		repeat (c) @(negedge ref_clk_i);
	endtask

	// bounded wait for the next heartbeat edge, c = cycles waited
	task automatic wait_toggle(output int c);
		logic v;
		v = word[`AOSW_BIT_PULSE];
		c = 0;
		while (word[`AOSW_BIT_PULSE] === v) begin
			@(negedge ref_clk_i);
			c++;
			if (c > 64) begin
				errors++;
				final_report();
			end
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{nrst_i, conv_err_i, speed_high_i, ext_supply_i} = 4'h0;
		{nvm_write_busy_i, diag_pass_i, diag_fault_i} = 3'h0;
		limits = '{upper: 16'h0800, lower: 16'h0100};
		settle(16);
		nrst_i = 1'b1;
		check(word, 16'h0000);
		// read, write, read; a start while busy must not change the kind
		host.start_xfer(1'b0);
		for (int k = 0; k < 3; k++) begin
			settle(2);
			check(word & 16'h0007, 16'h0001);
			if (k == 0) host.start_xfer(1'b1);
			host.end_xfer();
			settle(2);
			check(word & 16'h0007, k[0] ? 16'h0004 : 16'h0002);
			if (k < 2) host.start_xfer(~k[0]);
		end
		host.end_xfer();
		settle(2);
		check(word & 16'h0007, 16'h0002);
		// limit boundaries inclusive; invalid word dropped then cleared
		for (int i = 0; i < 6; i++) begin
			host.write_word(wd[i], wi[i]);
			settle(3);
			check(cfg, ec[i]);
			check(word & 16'h0118, {7'h0, el[i], 4'h0, wi[i], 3'h0});
		end
		// a conversion error in the same cycle spoils the word
		conv_err_i = 1'b1;
		host.write_word(16'h0300, 1'b0);
		conv_err_i = 1'b0;
		settle(3);
		check(cfg, 16'h0400);
		check(word & 16'h0010, 16'h0010);
		host.write_word(16'h0200, 1'b0);
		settle(3);
		check(word & 16'h0010, 16'h0000);
		check(16'(n_apply), 16'h0006);
		// levels and diagnostic result
		speed_high_i = 1'b1;
		ext_supply_i = 1'b1;
		diag_pass_i = 1'b1;
		settle(1);
		diag_pass_i = 1'b0;
		settle(2);
		check(word & 16'h1220, 16'h1220);
		speed_high_i = 1'b0;
		ext_supply_i = 1'b0;
		diag_fault_i = 1'b1;
		settle(1);
		diag_fault_i = 1'b0;
		settle(2);
		check(word & 16'h1220, 16'h0000);
		// heartbeat: both half periods, freeze over a write, then resume
		wait_toggle(n);
		for (int j = 0; j < 2; j++) begin
			wait_toggle(n);
			check(16'(n), 16'(HB));
		end
		nvm_write_busy_i = 1'b1;
		hb = word[`AOSW_BIT_PULSE];
		repeat (20) begin
			@(negedge ref_clk_i);
			check(16'(word[`AOSW_BIT_PULSE]), 16'(hb));
		end
		nvm_write_busy_i = 1'b0;
		// frozen one count into the half period: a restart would add one
		wait_toggle(n);
		check(16'(n), 16'(HB));
		wait_toggle(n);
		check(16'(n), 16'(HB));
		check(word & `AOSW_RSVD_MASK, 16'h0000);
		final_report();
	end
endmodule // tb
